// >>> e1nb_consts.svh
// constants for the e1 circular and spare bit buffers
`ifndef E1NB_CONSTS_SVH
`define E1NB_CONSTS_SVH
`define E1NB_PG_TXA   4'h9
`define E1NB_PG_TXB   4'ha
`define E1NB_PG_RXA   4'hb
`define E1NB_PG_RXB   4'hc
`define E1NB_PG_TXS   4'hd
`define E1NB_PG_RXS   4'he
`define E1NB_WIN_BIT  4
`define E1NB_NB_LAST  4'h4
`define E1NB_NB_BYTES 5
`define E1NB_MF_START 4'h0
`define E1NB_TS0      5'h00
`define E1NB_SLOTS    32
`define E1NB_CB_DEPTH 16
`define E1NB_FIFO_DEP 8
`define E1NB_RD_NONE  8'h00
`define E1NB_SB_RESET 8'h00
`endif

// >>> e1nb_pkg.sv
// types shared by the e1 buffer block
package e1nb_pkg;
    typedef logic [7:0] e1nb_byte_t;
    typedef logic [3:0] e1nb_idx_t;
    typedef struct packed {
        logic       to_a;
        logic       to_b;
        e1nb_idx_t  idx;
        e1nb_byte_t data;
    } e1nb_rxw_s;
endpackage

// >>> e1nb_fifo.sv
// small synchronous fifo between receive engine and receive buffers
`timescale 1ns/1ps
module e1nb_fifo
    import e1nb_pkg::*;
#(
    parameter int W = 14,
    parameter int D = 8
)
(
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic [AW:0]   next_cnt;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign out_valid_o = (cnt != '0);
    assign out_data_o  = mem[rp];
    assign next_cnt    = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge ref_clk_i)
    begin
        if (ce_i && push)
            mem[wp] <= in_data_i;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp         <= '0;
            rp         <= '0;
            cnt        <= '0;
            in_ready_o <= 1'b1;
        end
        else if (ce_i)
        begin
            wp         <= push ? wp + 1'b1 : wp;
            rp         <= pop ? rp + 1'b1 : rp;
            cnt        <= next_cnt;
            in_ready_o <= (next_cnt != (AW+1)'(D));
        end
    end
endmodule

// >>> e1nb_bufs.sv
// e1 transmit/receive circular buffers and spare bit buffers
// Functional notes
// - tx circular buffer a: 16 bytes, page 09h, 10000-11111, processor mode only
// - tx circular buffers keep contents through soft and hardware reset
// - tx buffer a bytes sent in slots with connect a set, index 0-15
// - tx circular buffer b: 16 bytes, page 0ah, 10000-11111, processor mode only
// - tx buffer b bytes sent in slots with connect b set and connect a clear
// - rx buffer a: page 0bh, records connect-a slots, processor mode only
// - rx buffer b: page 0ch, records connect-b slots, processor mode only
// - tx spare store: five bytes at page 0dh, 10000-10100, bytes 0-4
// - tx spare store acts only in processor mode with source select set
// - tx spare store survives soft reset, cleared by hardware reset
// - crc-4 on: byte n feeds bit n+4 of slot 0, frames 1-15 odd
// - crc-4 off: spare bits sent over eight consecutive odd frames
// - rx spare store: five bytes at page 0eh, 10000-10100, processor mode only
// - rx spare byte n captures bit n+4 of slot 0 in odd frames
// - slot connect takes effect from the next multiframe boundary
// - source select one uses tx spare store, zero uses fixed field
// - circular buffers unreachable by host in serial stream access mode
`timescale 1ns/1ps
`include "e1nb_consts.svh"
module e1nb_bufs
    import e1nb_pkg::*;
#(
    parameter int FIFO_DEPTH = `E1NB_FIFO_DEP
)
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // mode and control
    input  wire logic       proc_mode_i,
    input  wire logic       soft_rst_i,
    input  wire logic       crc4_i,
    input  wire logic       spare_bits_source_select_i,
    input  wire logic [4:0] fixed_spare_bits_field_i,
    // host paged access
    input  wire logic [3:0] page_i,
    input  wire logic [4:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // transmit frame engine
    input  wire logic       tx_req_i,
    input  wire logic [4:0] tx_slot_i,
    input  wire logic [3:0] tx_frame_i,
    input  wire logic       tx_slot_connect_a_i,
    input  wire logic       tx_slot_connect_b_i,
    output logic      [7:0] tx_byte_o,
    output logic            tx_buf_hit_o,
    output logic      [4:0] tx_spare_bits_o,
    // receive frame engine
    input  wire logic       rx_valid_i,
    input  wire logic [4:0] rx_slot_i,
    input  wire logic [3:0] rx_frame_i,
    input  wire logic [7:0] rx_byte_i,
    input  wire logic [4:0] rx_spare_i,
    input  wire logic       rx_slot_connect_a_i,
    input  wire logic       rx_slot_connect_b_i,
    output logic            rx_ready_o
);
    // buffer storage
    e1nb_byte_t tx_circ_buf_a [`E1NB_CB_DEPTH];
    e1nb_byte_t tx_circ_buf_b [`E1NB_CB_DEPTH];
    e1nb_byte_t rx_circ_buf_a [`E1NB_CB_DEPTH];
    e1nb_byte_t rx_circ_buf_b [`E1NB_CB_DEPTH];
    e1nb_byte_t tx_spare_bits_store [`E1NB_NB_BYTES];
    e1nb_byte_t rx_spare_bits_store [`E1NB_NB_BYTES];

    // connects latched at multiframe start, and odd-frame counters
    logic [`E1NB_SLOTS-1:0] tx_act_a;
    logic [`E1NB_SLOTS-1:0] tx_act_b;
    logic [`E1NB_SLOTS-1:0] rx_act_a;
    logic [`E1NB_SLOTS-1:0] rx_act_b;
    logic [2:0]             tx_odd_cnt;
    logic [2:0]             rx_odd_cnt;

    // host decode
    wire       e1nb_win = addr_i[`E1NB_WIN_BIT];
    wire [3:0] hidx     = addr_i[3:0];
    wire       nb_ok    = e1nb_win & (hidx <= `E1NB_NB_LAST);
    wire hit_txa = proc_mode_i & e1nb_win & (page_i == `E1NB_PG_TXA);
    wire hit_txb = proc_mode_i & e1nb_win & (page_i == `E1NB_PG_TXB);
    wire hit_rxa = proc_mode_i & e1nb_win & (page_i == `E1NB_PG_RXA);
    wire hit_rxb = proc_mode_i & e1nb_win & (page_i == `E1NB_PG_RXB);
    wire hit_txs = proc_mode_i & nb_ok & (page_i == `E1NB_PG_TXS);
    wire hit_rxs = proc_mode_i & nb_ok & (page_i == `E1NB_PG_RXS);
    wire [2:0] sidx = hidx[2:0];

    wire e1nb_byte_t rd_val =
        hit_txa ? tx_circ_buf_a[hidx] :
        hit_txb ? tx_circ_buf_b[hidx] :
        hit_rxa ? rx_circ_buf_a[hidx] :
        hit_rxb ? rx_circ_buf_b[hidx] :
        hit_txs ? tx_spare_bits_store[sidx] :
        hit_rxs ? rx_spare_bits_store[sidx] : `E1NB_RD_NONE;

    // transmit slot selection; frame number is the buffer index
    wire tx_mf  = (tx_frame_i == `E1NB_MF_START);
    wire tx_eff_a = proc_mode_i & (tx_mf ? tx_slot_connect_a_i : tx_act_a[tx_slot_i]);
    wire tx_eff_b = proc_mode_i & (tx_mf ? tx_slot_connect_b_i : tx_act_b[tx_slot_i]);
    wire tx_ts0 = tx_req_i & (tx_slot_i == `E1NB_TS0) & tx_frame_i[0];
    // with crc-4 frame 1 lands on bit 7, frame 15 on bit 0; without it the odd-frame count picks the bit
    wire [2:0] tx_bpos = ~(crc4_i ? tx_frame_i[3:1] : tx_odd_cnt);
    wire tx_use_store = proc_mode_i & spare_bits_source_select_i;

    // receive selection
    wire rx_fire  = rx_valid_i & rx_ready_o;
    wire rx_mf    = (rx_frame_i == `E1NB_MF_START);
    wire rx_eff_a = proc_mode_i & (rx_mf ? rx_slot_connect_a_i : rx_act_a[rx_slot_i]);
    wire rx_eff_b = proc_mode_i & (rx_mf ? rx_slot_connect_b_i : rx_act_b[rx_slot_i]);
    wire rx_ts0   = rx_fire & proc_mode_i & (rx_slot_i == `E1NB_TS0) & rx_frame_i[0];
    wire [2:0] rx_bpos = ~(crc4_i ? rx_frame_i[3:1] : rx_odd_cnt);

    e1nb_rxw_s fin;
    e1nb_rxw_s fout;
    logic      fout_valid;
    assign fin.to_a = rx_eff_a;
    assign fin.to_b = rx_eff_b;
    assign fin.idx  = rx_frame_i;
    assign fin.data = rx_byte_i;
    wire fin_valid  = rx_valid_i & (rx_eff_a | rx_eff_b);
    // buffer memories have one read port; a host read wins, the fifo absorbs it
    wire fout_ready = ~(rd_i & (hit_rxa | hit_rxb));
    wire drain      = fout_valid & fout_ready;
    logic fifo_ready;

    e1nb_fifo #(
        .W ($bits(e1nb_rxw_s)),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (fin_valid),
        .in_data_i   (fin),
        .in_ready_o  (fifo_ready),
        .out_valid_o (fout_valid),
        .out_data_o  (fout),
        .out_ready_i (fout_ready)
    );
    assign rx_ready_o = fifo_ready;

    // no reset on the tx buffers: contents survive both resets
    always_ff @(posedge ref_clk_i)
    begin
        if (ce_i && wr_i && hit_txa)
            tx_circ_buf_a[hidx] <= wdata_i;
        if (ce_i && wr_i && hit_txb)
            tx_circ_buf_b[hidx] <= wdata_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (ce_i && drain && fout.to_a)
            rx_circ_buf_a[fout.idx] <= fout.data;
        if (ce_i && drain && fout.to_b)
            rx_circ_buf_b[fout.idx] <= fout.data;
    end

    // per spare byte: host write, transmit pick and receive capture
    for (genvar n = 0; n < `E1NB_NB_BYTES; n++)
    begin : g_sb
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                tx_spare_bits_store[n] <= `E1NB_SB_RESET;
            else if (ce_i && wr_i && hit_txs && sidx == 3'(n))
                tx_spare_bits_store[n] <= wdata_i;
        end
        always_ff @(posedge ref_clk_i)
        begin
            if (ce_i && rx_ts0)
                rx_spare_bits_store[n][rx_bpos] <= rx_spare_i[n];
        end
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                tx_spare_bits_o[n] <= 1'b0;
            else if (ce_i && tx_ts0)
                tx_spare_bits_o[n] <= tx_use_store ? tx_spare_bits_store[n][tx_bpos]
                                                   : fixed_spare_bits_field_i[n];
        end
    end

    // connect latches and odd-frame counters
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_act_a   <= '0;
            tx_act_b   <= '0;
            rx_act_a   <= '0;
            rx_act_b   <= '0;
            tx_odd_cnt <= '0;
            rx_odd_cnt <= '0;
        end
        else if (ce_i && soft_rst_i)
        begin
            tx_act_a   <= '0;
            tx_act_b   <= '0;
            rx_act_a   <= '0;
            rx_act_b   <= '0;
            tx_odd_cnt <= '0;
            rx_odd_cnt <= '0;
        end
        else if (ce_i)
        begin
            if (tx_req_i && tx_mf)
            begin
                tx_act_a[tx_slot_i] <= tx_slot_connect_a_i;
                tx_act_b[tx_slot_i] <= tx_slot_connect_b_i;
            end
            if (rx_fire && rx_mf)
            begin
                rx_act_a[rx_slot_i] <= rx_slot_connect_a_i;
                rx_act_b[rx_slot_i] <= rx_slot_connect_b_i;
            end
            if (tx_ts0 && !crc4_i)
                tx_odd_cnt <= tx_odd_cnt + 1'b1;
            if (rx_ts0 && !crc4_i)
                rx_odd_cnt <= rx_odd_cnt + 1'b1;
        end
    end

    // host read data and transmit byte
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o      <= `E1NB_RD_NONE;
            tx_byte_o    <= `E1NB_RD_NONE;
            tx_buf_hit_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rd_i)
                rdata_o <= rd_val;
            if (tx_req_i)
            begin
                // buffer a wins when a slot is tied to both
                tx_byte_o    <= tx_eff_a ? tx_circ_buf_a[tx_frame_i]
                                         : tx_circ_buf_b[tx_frame_i];
                tx_buf_hit_o <= tx_eff_a | tx_eff_b;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    chk_host_blocked: assert property (
        ce_i && rd_i && !proc_mode_i |=> rdata_o == `E1NB_RD_NONE)
        else $error("buffer read outside processor mode returned data");
    chk_txa_readback: assert property (
        ce_i && wr_i && hit_txa ##1 ce_i && rd_i && hit_txa && hidx == $past(hidx)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("tx buffer a readback mismatch");
    chk_txb_readback: assert property (
        ce_i && wr_i && hit_txb ##1 ce_i && rd_i && hit_txb && hidx == $past(hidx)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("tx buffer b readback mismatch");
    chk_nb_range: assert property (
        ce_i && rd_i && page_i == `E1NB_PG_TXS && hidx > `E1NB_NB_LAST |=> rdata_o == `E1NB_RD_NONE)
        else $error("spare store read past byte four not zero");
    chk_spare_fixed: assert property (
        ce_i && tx_ts0 && !spare_bits_source_select_i
        |=> tx_spare_bits_o == $past(fixed_spare_bits_field_i))
        else $error("fixed spare field not used");
    chk_hit_mode: assert property (
        ce_i && tx_req_i && !proc_mode_i |=> !tx_buf_hit_o)
        else $error("tx buffer used outside processor mode");
    chk_rxa_land: assert property (
        ce_i && drain && fout.to_a |=> rx_circ_buf_a[$past(fout.idx)] == $past(fout.data))
        else $error("rx byte did not land in buffer a");
    chk_rxb_land: assert property (
        ce_i && drain && fout.to_b |=> rx_circ_buf_b[$past(fout.idx)] == $past(fout.data))
        else $error("rx byte did not land in buffer b");
    chk_rx_readonly: assert property (
        ce_i && wr_i && hit_rxa && !drain |=> rx_circ_buf_a[$past(hidx)] == $past(rx_circ_buf_a[hidx]))
        else $error("host write changed rx buffer a");
    chk_odd_count: assert property (
        ce_i && !soft_rst_i && tx_ts0 && !crc4_i |=> tx_odd_cnt == $past(tx_odd_cnt) + 3'h1)
        else $error("odd frame counter did not advance");
    chk_connect_mf: assert property (
        ce_i && tx_req_i && !tx_mf && proc_mode_i && !tx_act_a[tx_slot_i] && !tx_act_b[tx_slot_i]
        |=> !tx_buf_hit_o)
        else $error("connect took effect before multiframe start");
    chk_txs_readback: assert property (
        ce_i && wr_i && hit_txs ##1 ce_i && rd_i && hit_txs && hidx == $past(hidx)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("tx spare store readback mismatch");
    chk_spare_reset: assert property (
        $fell(rst_i) |-> tx_spare_bits_store[0] == `E1NB_SB_RESET && tx_spare_bits_store[4] == `E1NB_SB_RESET)
        else $error("tx spare store not cleared by reset");
    chk_rd_hold: assert property (
        !(ce_i && rd_i) |=> $stable(rdata_o))
        else $error("read data changed without a read");
    chk_tx_hold: assert property (
        !(ce_i && tx_req_i) |=> $stable(tx_byte_o) && $stable(tx_buf_hit_o))
        else $error("tx byte changed without a request");
    chk_spare_hold: assert property (
        !(ce_i && tx_ts0) |=> $stable(tx_spare_bits_o))
        else $error("spare bits changed without slot zero");

    cov_tx_hit: cover property (ce_i && tx_req_i && tx_eff_a ##1 tx_buf_hit_o);
    cov_rx_full: cover property (!rx_ready_o);
    cov_spare_store: cover property (ce_i && tx_ts0 && tx_use_store && crc4_i);
    cov_rx_spare: cover property (ce_i && rx_ts0 && !crc4_i);
    cov_b2b_read: cover property (ce_i && wr_i && hit_txs ##1 ce_i && rd_i && hit_txs);
endmodule

// >>> e1nb_eng_model.sv
// behavioural receive frame engine feeding the buffer block
`timescale 1ns/1ps
module e1nb_eng_model
(
    // clock and handshake
    input  wire logic ref_clk_i,
    input  wire logic rx_ready_i,
    // receive stream
    output logic       rx_valid_o,
    output logic [4:0] rx_slot_o,
    output logic [3:0] rx_frame_o,
    output logic [7:0] rx_byte_o,
    output logic [4:0] rx_spare_o,
    output logic       rx_con_a_o,
    output logic       rx_con_b_o
);
    initial
    begin
        rx_valid_o = 1'b0;
        {rx_slot_o, rx_frame_o, rx_byte_o, rx_spare_o, rx_con_a_o, rx_con_b_o} = '0;
    end

    // one slot, held until accepted; bounded wait so a stuck ready cannot hang
    task automatic send(input logic [4:0] s, input logic [3:0] f, input logic [7:0] b,
                        input logic [4:0] sp, input logic ca, input logic cb);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        #1;
        {rx_slot_o, rx_frame_o, rx_byte_o, rx_spare_o, rx_con_a_o, rx_con_b_o} = {s, f, b, sp, ca, cb};
        rx_valid_o = 1'b1;
        while (rx_ready_i !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        @(posedge ref_clk_i);
        #1;
        rx_valid_o = 1'b0;
        // released slot, byte and spare lines show inverse data; frame and connect lines keep the last value
        {rx_slot_o, rx_byte_o, rx_spare_o} = ~{s, b, sp};
    endtask
endmodule

// >>> tb.sv
// self-checking bench for the e1 buffer block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
    import e1nb_pkg::*;
    logic        clk, rst, ce, pm, srst, crc4, sel, wr, rd, treq, tca, tcb, hit, rxv, rxrdy, rca, rcb;
    logic [3:0]  page, tfr, rfr;
    logic [4:0]  addr, fix, tslot, tsp, rslot, rsp;
    logic [7:0]  wd, rdata, tbyte, rbyte, got;
    logic [4:0]  rsv = 5'h16;
    int          bad_count = 0;
    int          n_tests = 0;
    // page, address, write data, expected read
    logic [24:0] rows [13] = '{{4'h9, 5'h10, 8'h11, 8'h11}, {4'h9, 5'h15, 8'h55, 8'h55}, {4'h9, 5'h1f, 8'hff, 8'hff},
        {4'ha, 5'h10, 8'h22, 8'h22}, {4'ha, 5'h15, 8'h66, 8'h66}, {4'hd, 5'h10, 8'h80, 8'h80},
        {4'hd, 5'h11, 8'h40, 8'h40}, {4'hd, 5'h12, 8'h20, 8'h20}, {4'hd, 5'h13, 8'h10, 8'h10},
        {4'hd, 5'h14, 8'h08, 8'h08}, {4'hd, 5'h15, 8'h77, 8'h00}, {4'h9, 5'h0f, 8'h99, 8'h00},
        {4'h7, 5'h10, 8'h44, 8'h00}};

    e1nb_bufs #(.FIFO_DEPTH(8)) u_e1nb_bufs (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .proc_mode_i(pm),
        .soft_rst_i(srst), .crc4_i(crc4), .spare_bits_source_select_i(sel), .fixed_spare_bits_field_i(fix),
        .page_i(page), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wd), .rdata_o(rdata),
        .tx_req_i(treq), .tx_slot_i(tslot), .tx_frame_i(tfr), .tx_slot_connect_a_i(tca),
        .tx_slot_connect_b_i(tcb), .tx_byte_o(tbyte), .tx_buf_hit_o(hit), .tx_spare_bits_o(tsp),
        .rx_valid_i(rxv), .rx_slot_i(rslot), .rx_frame_i(rfr), .rx_byte_i(rbyte), .rx_spare_i(rsp),
        .rx_slot_connect_a_i(rca), .rx_slot_connect_b_i(rcb), .rx_ready_o(rxrdy));

    e1nb_eng_model u_e1nb_eng_model (.ref_clk_i(clk), .rx_ready_i(rxrdy), .rx_valid_o(rxv), .rx_slot_o(rslot),
        .rx_frame_o(rfr), .rx_byte_o(rbyte), .rx_spare_o(rsp), .rx_con_a_o(rca), .rx_con_b_o(rcb));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic hw(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {page, addr, wd, wr} = {p, a, d, 1'b1};
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask

    task automatic hr(input logic [3:0] p, input logic [4:0] a);
        @(posedge clk);
        #1;
        {page, addr, rd} = {p, a, 1'b1};
        @(posedge clk);
        #1;
        rd = 1'b0;
        got = rdata;
    endtask

    // write, then read the same byte on the very next edge
    task automatic hwr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {page, addr, wd, wr} = {p, a, d, 1'b1};
        @(posedge clk);
        #1;
        {wr, rd} = 2'b01;
        @(posedge clk);
        #1;
        rd = 1'b0;
        got = rdata;
    endtask

    task automatic tx(input logic [4:0] s, input logic [3:0] f, input logic a, input logic b);
        @(posedge clk);
        #1;
        {tslot, tfr, tca, tcb, treq} = {s, f, a, b, 1'b1};
        @(posedge clk);
        #1;
        treq = 1'b0;
    endtask

    task automatic test_done();
        $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        {rst, ce, pm, srst, crc4, sel, fix, wr, rd, treq} = {4'b1110, 2'b11, 5'h0d, 3'b000};
        {page, addr, wd, tslot, tfr, tca, tcb} = '0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK({rdata, tbyte, hit, tsp, rxrdy}, {8'h00, 8'h00, 1'b0, 5'h00, 1'b1})
        for (int i = 0; i < 13; i++)
        begin
            hw(rows[i][24:21], rows[i][20:16], rows[i][15:8]);
            hr(rows[i][24:21], rows[i][20:16]);
            `CHK(got, rows[i][7:0])
        end
        // back to back access; spare byte 3 keeps its value for the spare tests
        hwr(4'h9, 5'h13, 8'h5a); `CHK(got, 8'h5a)
        hwr(4'ha, 5'h13, 8'ha5); `CHK(got, 8'ha5)
        hwr(4'hd, 5'h13, 8'h10); `CHK(got, 8'h10)
        // connect sampled in frame 0, held for the rest of the multiframe
        tx(5'd3, 4'd0, 1'b1, 1'b0); `CHK({hit, tbyte}, {1'b1, 8'h11})
        tx(5'd4, 4'd0, 1'b0, 1'b0); `CHK(hit, 1'b0)
        tx(5'd7, 4'd0, 1'b0, 1'b1); `CHK({hit, tbyte}, {1'b1, 8'h22})
        tx(5'd8, 4'd0, 1'b1, 1'b1); `CHK({hit, tbyte}, {1'b1, 8'h11})
        tx(5'd3, 4'd5, 1'b0, 1'b0); `CHK({hit, tbyte}, {1'b1, 8'h55})
        tx(5'd4, 4'd5, 1'b1, 1'b0); `CHK(hit, 1'b0)
        tx(5'd7, 4'd5, 1'b0, 1'b0); `CHK({hit, tbyte}, {1'b1, 8'h66})
        tx(5'd3, 4'd15, 1'b0, 1'b0); `CHK({hit, tbyte}, {1'b1, 8'hff})
        for (int k = 0; k < 16; k++)
        begin
            // second pass without crc-4: label stays frame 1, odd frames are counted
            crc4 = (k < 8);
            tx(5'd0, (k < 8) ? 4'(2 * k + 1) : 4'd1, 1'b0, 1'b0);
            `CHK(tsp, (k[2:0] < 5) ? (5'h01 << k[2:0]) : 5'h00)
        end
        crc4 = 1'b1;
        sel = 1'b0;
        tx(5'd0, 4'd1, 1'b0, 1'b0); `CHK(tsp, 5'h0d)
        sel = 1'b1;
        u_e1nb_eng_model.send(5'd5, 4'd0, 8'h33, 5'h00, 1'b1, 1'b0);
        u_e1nb_eng_model.send(5'd6, 4'd0, 8'hc4, 5'h00, 1'b0, 1'b1);
        u_e1nb_eng_model.send(5'd0, 4'd3, 8'h00, rsv, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        hr(4'hb, 5'h10); `CHK(got, 8'h33)
        hr(4'hc, 5'h10); `CHK(got, 8'hc4)
        hw(4'hb, 5'h10, 8'hff);
        hr(4'hb, 5'h10); `CHK(got, 8'h33)
        // without crc-4 the first odd frame lands on bit 7 whatever its label
        crc4 = 1'b0;
        u_e1nb_eng_model.send(5'd0, 4'd9, 8'h00, ~rsv, 1'b0, 1'b0);
        crc4 = 1'b1;
        for (int n = 0; n < 5; n++)
        begin
            hr(4'he, 5'h10 + 5'(n)); `CHK({got[7], got[6]}, {~rsv[n], rsv[n]})
        end
        // host reads stall the drain, so the fifo fills and refuses
        {page, addr, rd} = {4'hb, 5'h11, 1'b1};
        for (int i = 0; i < 8; i++)
            u_e1nb_eng_model.send(5'd9, 4'd0, 8'(i), 5'h00, 1'b1, 1'b0);
        `CHK(rxrdy, 1'b0)
        rd = 1'b0;
        repeat (16) @(posedge clk);
        `CHK(rxrdy, 1'b1)
        hr(4'hb, 5'h10); `CHK(got, 8'h07)
        pm = 1'b0;
        hr(4'h9, 5'h10); `CHK(got, 8'h00)
        tx(5'd3, 4'd0, 1'b1, 1'b0); `CHK(hit, 1'b0)
        tx(5'd0, 4'd1, 1'b0, 1'b0); `CHK(tsp, 5'h0d)
        pm = 1'b1;
        srst = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        hr(4'hd, 5'h10); `CHK(got, 8'h80)
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        hr(4'h9, 5'h10); `CHK(got, 8'h11)
        hr(4'ha, 5'h10); `CHK(got, 8'h22)
        hr(4'hd, 5'h10); `CHK(got, 8'h00)
        test_done();
    end

    // whole run is a few hundred cycles; this margin only cuts a hang
    initial
    begin
        #(5000 * 4);
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end
endmodule
